// ### core/ddr_clock_ratio_strap_capture.sv
/*
 * strap capture at hard reset release and memory clocking control,
 * with an axi4-lite register slave.
 * assumes clock_i is the 125 MHz platform bus clock; strap pins and
 * hard_reset_n arrive asynchronously; the memory pll lives outside.
 */
`timescale 1ns/1ps
module ddr_clock_ratio_strap_capture (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // hard reset pin
    input wire logic hard_reset_n_i,
    // ratio strap pins: bit2, bit1, bit0
    input wire logic [2:0] mem_ratio_strap_in_i,
    output logic [2:0] mem_ratio_strap_out_o,
    output logic [2:0] mem_ratio_strap_oe_n_o,
    // clock mode strap pin, pulled up on chip
    input wire logic clk_mode_strap_in_i,
    output logic clk_mode_strap_out_o,
    output logic clk_mode_strap_oe_n_o,
    output logic clk_mode_pullup_en_o,
    // strap receiver enable
    output logic strap_rx_en_o,
    // memory clocking
    output logic mem_async_o,
    output logic mem_clk_run_o,
    output logic mem_bus_en_o,
    output logic mem_ctl_en_o,
    output logic [3:0] mem_pll_mult_o,
    output logic mem_pll_en_o,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    // ****************************************
    // types and helpers
    // ****************************************
    typedef enum logic [1:0] {ST_SAMPLE, ST_HOLD, ST_RUN} cap_e;

    typedef struct packed {
        cap_e fsm;
        logic [2:0] hold_cnt;
        logic [2:0] shadow_ratio;
        logic shadow_mode;
        logic [2:0] ratio;
        logic mode_async;
        logic captured;
        logic run_req;
        logic [3:0] pin_out;
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } top_s;

    // ratio code to data-rate multiplier, zero when unsupported
    function automatic logic [3:0] ratio_mult(input logic [2:0] code);
        case (code)
            3'h0: ratio_mult = 4'h3;
            3'h1: ratio_mult = 4'h4;
            3'h2: ratio_mult = 4'h6;
            3'h3: ratio_mult = 4'h8;
            3'h4: ratio_mult = 4'hA;
            default: ratio_mult = 4'h0;
        endcase
    endfunction : ratio_mult

    // address known to the register file
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == strap_clk_pkg::CTRL_ADDR) || (a == strap_clk_pkg::STATUS_ADDR)
            || (a == strap_clk_pkg::PINOUT_ADDR);
    endfunction : addr_ok

    top_s state_q;
    top_s state_d;
    logic hrst_n_s;
    logic hrst_asserted;
    logic [3:0] strap_s;
    logic unsup;
    logic running;
    logic bus_half_en;
    logic wr_fire;
    logic [31:0] status_word;

    // ****************************************
    // pin synchronisers
    // ****************************************
    bit_sync #(.WIDTH(1)) u_hrst_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i(hard_reset_n_i),
        .rst_val_i(1'b0), // reset reads as hard reset held, no false release
        .sync_o(hrst_n_s)
    );

    bit_sync #(.WIDTH(4)) u_strap_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i({clk_mode_strap_in_i, mem_ratio_strap_in_i}),
        .rst_val_i({strap_clk_pkg::MODE_SYNC, 3'h0}), // defaults if nothing sampled yet
        .sync_o(strap_s)
    );

    assign hrst_asserted = !hrst_n_s;

    // ****************************************
    // clock derivation
    // ****************************************
    // unsupported code never starts the memory clock
    assign unsup = state_q.ratio > strap_clk_pkg::RATIO_MAX;
    assign running = (state_q.fsm == ST_RUN) && state_q.captured && state_q.run_req && !unsup;

    half_rate_en u_bus_div (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .run_i(running && !state_q.mode_async),
        .en_o(bus_half_en)
    );

    // one mode signal feeds both controllers
    assign mem_async_o = state_q.mode_async;
    assign mem_clk_run_o = running;
    assign mem_bus_en_o = bus_half_en;
    // complex runs at data rate: every platform clock in sync mode
    assign mem_ctl_en_o = running && !state_q.mode_async;
    // async: pll multiplies its reference by the decoded ratio
    assign mem_pll_en_o = running && state_q.mode_async;
    assign mem_pll_mult_o = ratio_mult(state_q.ratio);

    // ****************************************
    // strap pins
    // ****************************************
    // inputs until the hold ends, then driven outputs
    assign mem_ratio_strap_oe_n_o = (state_q.fsm == ST_RUN) ? 3'h0 : 3'h7;
    assign clk_mode_strap_oe_n_o = state_q.fsm != ST_RUN;
    assign mem_ratio_strap_out_o = state_q.pin_out[2:0];
    assign clk_mode_strap_out_o = state_q.pin_out[3];
    // pull-up and receiver drop together
    assign clk_mode_pullup_en_o = state_q.fsm != ST_RUN;
    assign strap_rx_en_o = state_q.fsm != ST_RUN;

    // ****************************************
    // status word
    // ****************************************
    always_comb begin
        status_word = 32'h0;
        status_word[strap_clk_pkg::ST_CAPT_BIT] = state_q.captured;
        status_word[strap_clk_pkg::ST_RATIO_LSB +: 3] = state_q.ratio;
        status_word[strap_clk_pkg::ST_ASYNC_BIT] = state_q.mode_async;
        status_word[strap_clk_pkg::ST_UNSUP_BIT] = unsup;
        status_word[strap_clk_pkg::ST_RUN_BIT] = running;
        status_word[strap_clk_pkg::ST_MULT_LSB +: 4] = ratio_mult(state_q.ratio);
    end

    assign wr_fire = state_q.aw_have && state_q.w_have && !state_q.bvalid;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        state_d = state_q;
        // capture sequence
        case (state_q.fsm)
            ST_SAMPLE: begin
                if (hrst_asserted) begin
                    state_d.shadow_ratio = strap_s[2:0];
                    state_d.shadow_mode = strap_s[3];
                end else begin
                    // latch values seen while reset was held
                    state_d.ratio = state_q.shadow_ratio;
                    state_d.mode_async = state_q.shadow_mode != strap_clk_pkg::MODE_SYNC;
                    state_d.captured = 1'b1;
                    state_d.hold_cnt = 3'h0;
                    state_d.fsm = ST_HOLD;
                end
            end
            ST_HOLD: begin
                state_d.hold_cnt = state_q.hold_cnt + 3'h1;
                if (state_q.hold_cnt == strap_clk_pkg::PULL_HOLD_CYC - 3'h1) begin
                    state_d.fsm = ST_RUN;
                end
            end
            ST_RUN: begin
                state_d.fsm = ST_RUN;
            end
            default: begin
                state_d.fsm = ST_SAMPLE;
            end
        endcase
        if (hrst_asserted && state_q.fsm != ST_SAMPLE) begin
            state_d.fsm = ST_SAMPLE;
            state_d.captured = 1'b0;
        end
        // write address and data, taken in any order
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            state_d.aw_have = 1'b1;
            state_d.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            state_d.w_have = 1'b1;
            state_d.wdata = s_axi_wdata_i;
            state_d.wstrb0 = s_axi_wstrb_i[0];
        end
        if (wr_fire) begin
            state_d.aw_have = 1'b0;
            state_d.w_have = 1'b0;
            state_d.bvalid = 1'b1;
            state_d.bresp = addr_ok(state_q.awaddr) ? strap_clk_pkg::RESP_OKAY
                : strap_clk_pkg::RESP_SLVERR;
            if (state_q.wstrb0 && state_q.awaddr == strap_clk_pkg::CTRL_ADDR) begin
                state_d.run_req = state_q.wdata[strap_clk_pkg::CTRL_RUN_BIT];
            end
            if (state_q.wstrb0 && state_q.awaddr == strap_clk_pkg::PINOUT_ADDR) begin
                state_d.pin_out = state_q.wdata[3:0];
            end
        end
        if (state_q.bvalid && s_axi_bready_i) begin
            state_d.bvalid = 1'b0;
        end
        // read channel
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            state_d.rvalid = 1'b1;
            state_d.rresp = addr_ok(s_axi_araddr_i) ? strap_clk_pkg::RESP_OKAY
                : strap_clk_pkg::RESP_SLVERR;
            case (s_axi_araddr_i)
                strap_clk_pkg::CTRL_ADDR: state_d.rdata = {31'h0, state_q.run_req};
                strap_clk_pkg::STATUS_ADDR: state_d.rdata = status_word;
                strap_clk_pkg::PINOUT_ADDR: state_d.rdata = {28'h0, state_q.pin_out};
                default: state_d.rdata = 32'h0;
            endcase
        end else if (state_q.rvalid && s_axi_rready_i) begin
            state_d.rvalid = 1'b0;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_q <= '0;
            state_q.fsm <= ST_SAMPLE;
            state_q.shadow_mode <= strap_clk_pkg::MODE_SYNC;
            state_q.run_req <= strap_clk_pkg::CTRL_RUN_RST;
            state_q.pin_out <= strap_clk_pkg::PINOUT_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // bus handshake outputs
    // ****************************************
    assign s_axi_awready_o = !state_q.aw_have && !state_q.bvalid;
    assign s_axi_wready_o = !state_q.w_have && !state_q.bvalid;
    assign s_axi_bvalid_o = state_q.bvalid;
    assign s_axi_bresp_o = state_q.bresp;
    assign s_axi_arready_o = !state_q.rvalid;
    assign s_axi_rvalid_o = state_q.rvalid;
    assign s_axi_rdata_o = state_q.rdata;
    assign s_axi_rresp_o = state_q.rresp;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence hrst_release_s;
        $fell(hrst_asserted);
    endsequence

    sequence quiet_after_s;
        hrst_release_s ##1 (!hrst_asserted) [*5];
    endsequence

    bus_half_rate_a: assert property (
        (running && !state_q.mode_async) [*3] |-> (mem_bus_en_o != $past(mem_bus_en_o)))
        else $error("memory bus enable not at half rate");

    ctl_data_rate_a: assert property (
        (running && !mem_async_o) |-> (mem_ctl_en_o && !mem_pll_en_o))
        else $error("controller enable not at platform rate in sync mode");

    ratio_decode_a: assert property (
        (state_q.ratio == 3'h4) |-> (mem_pll_mult_o == 4'hA))
        else $error("ratio code 100 not decoded to ten");

    async_pll_a: assert property (
        (running && mem_async_o) |-> (mem_pll_en_o && !mem_bus_en_o && mem_pll_mult_o != 4'h0))
        else $error("async mode without pll ratio");

    pins_input_a: assert property (
        hrst_asserted |=> (mem_ratio_strap_oe_n_o == 3'h7 && clk_mode_strap_oe_n_o))
        else $error("strap pins driven during hard reset");

    latch_stable_a: assert property (
        (state_q.fsm == ST_RUN) |=> (state_q.fsm != ST_RUN || $stable(state_q.ratio)))
        else $error("latched strap value changed after capture");

    pullup_hold_a: assert property (
        hrst_release_s |-> clk_mode_pullup_en_o [*5])
        else $error("pull-up dropped too early");

    pullup_off_a: assert property (
        quiet_after_s |-> (!clk_mode_pullup_en_o && !strap_rx_en_o
            && mem_ratio_strap_oe_n_o == 3'h0))
        else $error("pull-up or receiver still on after hold");

    default_mode_a: assert property (
        (state_q.fsm == ST_SAMPLE && !hrst_asserted && state_q.shadow_mode)
        |=> !mem_async_o)
        else $error("high mode strap did not select sync mode");

    unsup_block_a: assert property (
        (state_q.ratio > 3'h4) |-> (!mem_clk_run_o && !mem_bus_en_o && !mem_pll_en_o))
        else $error("memory clock started with unsupported ratio");
endmodule : ddr_clock_ratio_strap_capture

// ### core/strap_clk_pkg.sv
/*
 * constants for strap capture and memory clock derivation.
 * assumes a single 125 MHz platform bus clock and a 32-bit register bus.
 */
package strap_clk_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] PINOUT_ADDR = 8'h08;
    // ctrl fields
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RST = 1'b1;
    // status fields
    localparam int ST_CAPT_BIT = 0;
    localparam int ST_RATIO_LSB = 1;
    localparam int ST_ASYNC_BIT = 4;
    localparam int ST_UNSUP_BIT = 5;
    localparam int ST_RUN_BIT = 6;
    localparam int ST_MULT_LSB = 8;
    // pinout reset value
    localparam logic [3:0] PINOUT_RST = 4'h0;
    // ****************************************
    // strap encodings
    // ****************************************
    localparam logic [2:0] RATIO_MAX = 3'h4;
    localparam logic MODE_SYNC = 1'b1;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 125;
    localparam int PULL_HOLD_CLKS = 4;
    localparam logic [2:0] PULL_HOLD_CYC = 3'(PULL_HOLD_CLKS);
    // ****************************************
    // bus responses
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : strap_clk_pkg

// ### core/bit_sync.sv
/*
 * two-flop synchroniser for a group of pins.
 * assumes inputs are asynchronous to clock_i.
 */
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // pins in, synced out
    input wire logic [WIDTH-1:0] async_i,
    input wire logic [WIDTH-1:0] rst_val_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_s;
    sync_s state_q;
    sync_s state_d;

    // first stage feeds only the second
    always_comb begin
        state_d = state_q;
        state_d.s1 = async_i;
        state_d.s2 = state_q.s1;
    end

    // registers, held at the caller's level in reset
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_q.s1 <= rst_val_i;
            state_q.s2 <= rst_val_i;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_o = state_q.s2;
endmodule : bit_sync

// ### core/half_rate_en.sv
/*
 * one-cycle enable at half the clock rate while running.
 * assumes run_i comes from logic on clock_i.
 */
`timescale 1ns/1ps
module half_rate_en (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // control and enable
    input wire logic run_i,
    output logic en_o
);
    typedef struct packed {
        logic phase;
    } div_s;
    div_s state_q;
    div_s state_d;

    // phase toggles only while running
    always_comb begin
        state_d = state_q;
        state_d.phase = run_i ? !state_q.phase : 1'b0;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign en_o = run_i && state_q.phase;
endmodule : half_rate_en

// ### tb/strap_board_model.sv
/*
 * board side of the strap pins: system reset source and strap resistors.
 * assumes the device reports its pin drive through active-low enables.
 */
`timescale 1ns/1ps
module strap_board_model (
    // reset controller request
    input wire logic hard_reset_req_i,
    output logic hard_reset_n_o,
    // board strap fitting
    input wire logic [2:0] ratio_sel_i,
    input wire logic mode_pd_i,
    // device pin drive
    input wire logic [2:0] ratio_out_i,
    input wire logic [2:0] ratio_oe_n_i,
    input wire logic mode_out_i,
    input wire logic mode_oe_n_i,
    input wire logic mode_pullup_en_i,
    // resolved pin levels
    output logic [2:0] ratio_pin_o,
    output logic mode_pin_o
);
    // reset source holds the pin low while asked to
    // always a defined level, never floating
    assign hard_reset_n_o = ~hard_reset_req_i;
    // ratio pins carry board resistors only, device drive wins
    assign ratio_pin_o = (ratio_out_i & ~ratio_oe_n_i) | (ratio_sel_i & ratio_oe_n_i);
    // mode pin: drive, board pull-down, on-chip pull-up, else floating
    assign mode_pin_o = !mode_oe_n_i ? mode_out_i :
        mode_pd_i ? 1'h0 : mode_pullup_en_i ? 1'h1 : ~mode_out_i;
endmodule : strap_board_model

// ### tb/ddr_clock_ratio_strap_capture_tb.sv
/*
 * self-checking bench for strap capture and memory clock control.
 * assumes the board model resolves the strap pins; axi master in tasks.
 */
`timescale 1ns/1ps
module ddr_clock_ratio_strap_capture_tb;
    logic clock_i, rst_i, req, mode_pd, awvalid, wvalid, bready, arvalid, rready;
    logic [2:0] ratio_sel, r_out, r_oe_n, r_pin;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic hrn, m_pin, m_out, m_oe_n, pull, rx_en, m_async, run, bus_en, ctl_en, pll_en;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] mult;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] wdata_rd;
    logic [1:0] resp;
    // ****************************************
    // design and board
    // ****************************************
    ddr_clock_ratio_strap_capture dut (.clock_i(clock_i), .rst_i(rst_i), .hard_reset_n_i(hrn),
        .mem_ratio_strap_in_i(r_pin), .mem_ratio_strap_out_o(r_out),
        .mem_ratio_strap_oe_n_o(r_oe_n), .clk_mode_strap_in_i(m_pin),
        .clk_mode_strap_out_o(m_out), .clk_mode_strap_oe_n_o(m_oe_n),
        .clk_mode_pullup_en_o(pull), .strap_rx_en_o(rx_en), .mem_async_o(m_async),
        .mem_clk_run_o(run), .mem_bus_en_o(bus_en), .mem_ctl_en_o(ctl_en),
        .mem_pll_mult_o(mult), .mem_pll_en_o(pll_en), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready));
    strap_board_model board (.hard_reset_req_i(req), .hard_reset_n_o(hrn),
        .ratio_sel_i(ratio_sel), .mode_pd_i(mode_pd), .ratio_out_i(r_out),
        .ratio_oe_n_i(r_oe_n), .mode_out_i(m_out), .mode_oe_n_i(m_oe_n),
        .mode_pullup_en_i(pull), .ratio_pin_o(r_pin), .mode_pin_o(m_pin));
    // ****************************************
    // clock, watchdog, helpers
    // ****************************************
    initial begin
        clock_i = 1'h0;
        forever #4 clock_i = ~clock_i;
    end
    // cut a hang short
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic conclude();
        $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    function automatic logic [3:0] mult_of(input logic [2:0] c);
        case (c)
            3'h0: return 4'h3;
            3'h1: return 4'h4;
            3'h2: return 4'h6;
            3'h3: return 4'h8;
            3'h4: return 4'hA;
            default: return 4'h0;
        endcase
    endfunction : mult_of
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock_i);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= d;
        wvalid <= 1'h1;
        r = 2'h3;
        while (r === 2'h3) begin
            @(posedge clock_i);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid && bready) r = bresp;
        end
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock_i);
        araddr <= a;
        arvalid <= 1'h1;
        r = 2'h3;
        while (r === 2'h3) begin
            @(posedge clock_i);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid && rready) begin
                r = rresp;
                d = rdata;
            end
        end
    endtask : axi_read
    // ****************************************
    // scenarios
    // ****************************************
    task automatic capture(input logic [2:0] c, input logic pd);
        @(posedge clock_i);
        req <= 1'h1;
        ratio_sel <= c;
        mode_pd <= pd;
        repeat (4) @(posedge clock_i);
        #1 check({r_oe_n, m_oe_n, rx_en}, 5'h1F);
        check(pull, 1'h1);
        @(posedge clock_i);
        req <= 1'h0;
        repeat (6) @(posedge clock_i);
        #1 check({r_oe_n, m_oe_n, pull}, 5'h1F);
        @(posedge clock_i);
        #1 check({r_oe_n, m_oe_n, pull, rx_en}, 6'h00);
    endtask : capture
    task automatic check_cfg(input logic [2:0] c, input logic a);
        logic ok;
        logic [31:0] s;
        logic [1:0] r;
        int pulses;
        ok = (c <= strap_clk_pkg::RATIO_MAX);
        pulses = 0;
        check(mult, mult_of(c));
        check(run, ok);
        check(m_async, a);
        check(pll_en, ok & a);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_i);
            #1 pulses += bus_en;
            check(ctl_en, ok & ~a);
        end
        check(pulses, (ok & ~a) ? 2 : 0);
        s = 32'h0;
        s[strap_clk_pkg::ST_CAPT_BIT] = 1'h1;
        s[strap_clk_pkg::ST_RATIO_LSB +: 3] = c;
        s[strap_clk_pkg::ST_ASYNC_BIT] = a;
        s[strap_clk_pkg::ST_UNSUP_BIT] = ~ok;
        s[strap_clk_pkg::ST_RUN_BIT] = ok;
        s[strap_clk_pkg::ST_MULT_LSB +: 4] = mult_of(c);
        axi_read(strap_clk_pkg::STATUS_ADDR, wdata_rd, r);
        check(r, strap_clk_pkg::RESP_OKAY);
        check(wdata_rd, s);
        $display("config %0d mode %0d done", c, a);
    endtask : check_cfg
    initial begin
        rst_i = 1'h1;
        // power-on flow opens with the reset request held
        req = 1'h1;
        ratio_sel = 3'h0;
        mode_pd = 1'h0;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, arvalid} = 3'h0;
        bready = 1'h1;
        rready = 1'h1;
        repeat (3) @(posedge clock_i);
        rst_i <= 1'h0;
        #1 check({r_oe_n, m_oe_n, pull, run}, 6'h3E);
        axi_read(strap_clk_pkg::CTRL_ADDR, wdata_rd, resp);
        check(wdata_rd, 32'h1);
        axi_read(strap_clk_pkg::PINOUT_ADDR, wdata_rd, resp);
        check(wdata_rd, 32'h0);
        $display("reset state done");
        // every ratio code in sync mode, unsupported ones too
        for (int c = 0; c < 8; c++) begin
            capture(3'(c), 1'h0);
            check_cfg(3'(c), 1'h0);
        end
        // async mode, then strap changes after the latch
        capture(3'h3, 1'h1);
        check_cfg(3'h3, 1'h1);
        @(posedge clock_i);
        ratio_sel <= 3'h0;
        mode_pd <= 1'h0;
        repeat (4) @(posedge clock_i);
        #1 check({mult, m_async}, 5'h11);
        // run control gates the memory clock
        axi_write(strap_clk_pkg::CTRL_ADDR, 32'h0, resp);
        #1 check({resp, run, pll_en}, 4'h0);
        axi_write(strap_clk_pkg::CTRL_ADDR, 32'h1, resp);
        #1 check({run, pll_en}, 2'h3);
        $display("run control done");
        // pins return to output duty
        axi_write(strap_clk_pkg::PINOUT_ADDR, 32'hA, resp);
        #1 check({r_out, m_out, r_pin, m_pin}, 8'h55);
        axi_read(strap_clk_pkg::PINOUT_ADDR, wdata_rd, resp);
        check(wdata_rd, 32'hA);
        $display("pin output done");
        // unmapped address
        axi_write(8'h0C, 32'h1, resp);
        check(resp, strap_clk_pkg::RESP_SLVERR);
        axi_read(8'h0C, wdata_rd, resp);
        check(resp, strap_clk_pkg::RESP_SLVERR);
        check(wdata_rd, 32'h0);
        $display("unmapped access done");
        conclude();
    end
endmodule : ddr_clock_ratio_strap_capture_tb
